// >>> hdl/sbgt_timer.sv
`include "sbgt_cfg.svh"
`default_nettype none

// How it works
// - Sixteen-bit free-running interval timer or counter.
// - Timer modes use cycle clock, counters use pin.
// - Source, gate and sync bits pick mode.
// - Source bit 1, sync bit 2, gate 6.
// - Synchronisation follows the prescaler; async counts directly.
// - Bit 15 starts and stops counting.
// - Bit 13 halts timer during idle.
// - Gate bit ignored with external source.
// - Bits 5-4 divide by 1, 8, 64, 256.
// - Sync bit matters only with external source.
// - Source bit counts pin rising edges.
// - Count writes ignored in running sync counter.
// - Unimplemented control bits read as zero.

// ----------------------------------------------------------------------------
// Timer top level with APB register slave.
// ----------------------------------------------------------------------------
module sbgt_timer #(
   parameter int CNT_W = 16,
   parameter int PS_W  = 8
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        instruction_cycle_clock,
   input  wire logic        ext_count_clock_pin,
   input  wire logic        gate_in,
   input  wire logic        idle_mode,
   output logic             period_match_flag
);

   // -------------------------------------------------------------------------
   // Register state.
   // -------------------------------------------------------------------------
   logic [15:0]      ctrl_q;
   logic [15:0]      ctrl_d;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic [CNT_W-1:0] period_q;
   logic [CNT_W-1:0] period_d;
   logic             flag_q;
   logic             flag_d;
   logic [31:0]      prdata_q;
   logic [31:0]      prdata_d;
   logic             slverr_d;

   sbgt_pkg::sbgt_ctrl_s ctrl;
   sbgt_pkg::sbgt_mode_e mode;

   // -------------------------------------------------------------------------
   // Field view of the control register.
   // -------------------------------------------------------------------------
   assign ctrl.count_enable           = ctrl_q[`SBGT_BIT_ENABLE];
   assign ctrl.halt_in_idle           = ctrl_q[`SBGT_BIT_IDLE];
   assign ctrl.gate_accumulate_enable = ctrl_q[`SBGT_BIT_GATE];
   assign ctrl.prescale_select        = ctrl_q[`SBGT_BIT_PS_HI:`SBGT_BIT_PS_LO];
   assign ctrl.ext_clock_sync_select  = ctrl_q[`SBGT_BIT_SYNC];
   assign ctrl.clock_source_select    = ctrl_q[`SBGT_BIT_SRC];

   // Mode decode: gate only counts with the internal source, sync only with the pin.
   assign mode = !ctrl.clock_source_select
                 ? (ctrl.gate_accumulate_enable ? sbgt_pkg::SBGT_MODE_GATED
                                                : sbgt_pkg::SBGT_MODE_TIMER)
                 : (ctrl.ext_clock_sync_select  ? sbgt_pkg::SBGT_MODE_SYNC_CNT
                                                : sbgt_pkg::SBGT_MODE_ASYNC_CNT);

   // -------------------------------------------------------------------------
   // Input edges and gate.
   // -------------------------------------------------------------------------
   logic pin_level;
   logic pin_prev_q;
   logic pin_raw_rise;
   logic gate_level;
   logic cyc_prev_q;
   logic cyc_tick;

   // The pin level seen in status goes through two flops; counting uses the raw edge.
   sbgt_edge_sync u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_count_clock_pin),
      .level   (pin_level),
      .rise    ()
   );

   // The gate is a level from outside, so it is synchronised as well.
   sbgt_edge_sync u_gate_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (gate_in),
      .level   (gate_level),
      .rise    ()
   );

   // Edge of the raw pin and of the cycle enable; pins are taken as synchronous.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_prev_q <= 1'b0;
         cyc_prev_q <= 1'b0;
      end
      else
      begin
         pin_prev_q <= ext_count_clock_pin;
         cyc_prev_q <= instruction_cycle_clock;
      end
   end

   assign pin_raw_rise = ext_count_clock_pin && !pin_prev_q;
   assign cyc_tick     = instruction_cycle_clock && !cyc_prev_q;

   // -------------------------------------------------------------------------
   // Tick selection ahead of the prescaler.
   // -------------------------------------------------------------------------
   logic running;
   logic src_tick;
   logic ps_tick;
   logic ps_clr;
   logic sync_tick_q;
   logic count_tick;

   // Halt in idle only when asked; otherwise the timer keeps going.
   assign running = ctrl.count_enable && !(ctrl.halt_in_idle && idle_mode);
   assign ps_clr  = !ctrl.count_enable;

   // Synchronised counting uses the raw pin edge so the sync stage sits after
   // the prescaler; the two-flop path feeds only status.
   assign src_tick = !running ? 1'b0 :
                     (mode == sbgt_pkg::SBGT_MODE_TIMER)     ? cyc_tick :
                     (mode == sbgt_pkg::SBGT_MODE_GATED)     ? (cyc_tick && gate_level) :
                     pin_raw_rise;

   sbgt_prescaler #(
      .W (PS_W)
   ) u_prescaler (
      .pclk     (pclk),
      .presetn  (presetn),
      .clr      (ps_clr),
      .tick_in  (src_tick),
      .sel      (ctrl.prescale_select),
      .tick_out (ps_tick)
   );

   // Prescaled pin tick is re-timed by one flop in sync mode; async counts at once.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_tick_q <= 1'b0;
      else
         sync_tick_q <= ps_tick && (mode == sbgt_pkg::SBGT_MODE_SYNC_CNT);
   end

   assign count_tick = (mode == sbgt_pkg::SBGT_MODE_SYNC_CNT) ? (sync_tick_q && running)
                                                              : ps_tick;

   // -------------------------------------------------------------------------
   // APB decode.
   // -------------------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic hit_ctrl;
   logic hit_count;
   logic hit_period;
   logic hit_status;
   logic hit_any;
   logic lo_we;
   logic hi_we;
   logic count_locked;
   logic match;

   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && penable && !pwrite;
   assign hit_ctrl   = (paddr == `SBGT_OFS_CTRL);
   assign hit_count  = (paddr == `SBGT_OFS_COUNT);
   assign hit_period = (paddr == `SBGT_OFS_PERIOD);
   assign hit_status = (paddr == `SBGT_OFS_STATUS);
   assign hit_any    = hit_ctrl || hit_count || hit_period || hit_status;
   assign lo_we      = wr_en && pstrb[0];
   assign hi_we      = wr_en && pstrb[1];
   assign pready     = 1'b1;    // Zero wait states on every access.

   // A running synchronous counter refuses count writes.
   assign count_locked = ctrl.count_enable && (mode == sbgt_pkg::SBGT_MODE_SYNC_CNT);
   assign match        = count_tick && (count_q == period_q);

   // Byte-lane merge for control and period; unimplemented bits stay zero.
   assign ctrl_d = hit_ctrl
                   ? ({hi_we ? pwdata[15:8] : ctrl_q[15:8],
                       lo_we ? pwdata[7:0]  : ctrl_q[7:0]} & `SBGT_CTRL_MASK)
                   : ctrl_q;
   assign period_d = hit_period
                     ? {hi_we ? pwdata[15:8] : period_q[15:8],
                        lo_we ? pwdata[7:0]  : period_q[7:0]}
                     : period_q;

   // Software write wins over the tick only when allowed; match wraps to zero.
   assign count_d = (hit_count && (lo_we || hi_we) && !count_locked)
                    ? {hi_we ? pwdata[15:8] : count_q[15:8],
                       lo_we ? pwdata[7:0]  : count_q[7:0]}
                    : match      ? `SBGT_COUNT_RESET
                    : count_tick ? count_q + 1'b1
                    : count_q;

   // Write one to clear; a match in the same cycle keeps the flag set.
   assign flag_d = match || (flag_q && !(hit_status && lo_we && pwdata[0]));

   assign prdata_d = !rd_en     ? prdata_q :
                     hit_ctrl   ? {16'h0000, ctrl_q} :
                     hit_count  ? {16'h0000, count_q} :
                     hit_period ? {16'h0000, period_q} :
                     hit_status ? {28'h0000000, gate_level, pin_level, running, flag_q} :
                     32'h00000000;
   assign slverr_d = psel && penable && !hit_any;

   // -------------------------------------------------------------------------
   // Register updates.
   // -------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q   <= `SBGT_CTRL_RESET;
         count_q  <= `SBGT_COUNT_RESET;
         period_q <= `SBGT_PERIOD_RESET;
         flag_q   <= 1'b0;
      end
      else
      begin
         ctrl_q   <= ctrl_d;
         count_q  <= count_d;
         period_q <= period_d;
         flag_q   <= flag_d;
      end
   end

   // Read data is registered so it stands still between accesses.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else
         prdata_q <= prdata_d;
   end

   // With zero wait states the data must be valid in the access cycle itself.
   assign prdata            = rd_en ? prdata_d : prdata_q;
   assign pslverr           = slverr_d;
   assign period_match_flag = flag_q;

endmodule

`default_nettype wire

// >>> shared/sbgt_cfg.svh
`ifndef SBGT_CFG_SVH
`define SBGT_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the peripheral bus.
// ----------------------------------------------------------------------------
`define SBGT_OFS_CTRL      12'h000
`define SBGT_OFS_COUNT     12'h004
`define SBGT_OFS_PERIOD    12'h008
`define SBGT_OFS_STATUS    12'h00c

// ----------------------------------------------------------------------------
// Control register field positions.
// ----------------------------------------------------------------------------
`define SBGT_BIT_ENABLE    15
`define SBGT_BIT_IDLE      13
`define SBGT_BIT_GATE      6
`define SBGT_BIT_PS_HI     5
`define SBGT_BIT_PS_LO     4
`define SBGT_BIT_SYNC      2
`define SBGT_BIT_SRC       1
`define SBGT_CTRL_MASK     16'ha076
`define SBGT_CTRL_RESET    16'h0000

// ----------------------------------------------------------------------------
// Reset values and prescale terminal counts.
// ----------------------------------------------------------------------------
`define SBGT_COUNT_RESET   16'h0000
`define SBGT_PERIOD_RESET  16'hffff
`define SBGT_DIV1_LAST     8'h00
`define SBGT_DIV8_LAST     8'h07
`define SBGT_DIV64_LAST    8'h3f
`define SBGT_DIV256_LAST   8'hff

`endif

// >>> shared/sbgt_pkg.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Types shared by the timer files.
// ----------------------------------------------------------------------------
package sbgt_pkg;

   // Operating mode decoded from the control bits.
   typedef enum logic [1:0] {
      SBGT_MODE_TIMER,
      SBGT_MODE_GATED,
      SBGT_MODE_SYNC_CNT,
      SBGT_MODE_ASYNC_CNT
   } sbgt_mode_e;

   // Control register fields as a bundle.
   typedef struct packed {
      logic       count_enable;
      logic       halt_in_idle;
      logic       gate_accumulate_enable;
      logic [1:0] prescale_select;
      logic       ext_clock_sync_select;
      logic       clock_source_select;
   } sbgt_ctrl_s;

endpackage

`default_nettype wire

// >>> hdl/sbgt_prescaler.sv
`include "sbgt_cfg.svh"
`default_nettype none

// ----------------------------------------------------------------------------
// Prescaler: passes one tick out of 1, 8, 64 or 256 ticks in.
// ----------------------------------------------------------------------------
module sbgt_prescaler #(
   parameter int W = 8
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clr,
   input  wire logic       tick_in,
   input  wire logic [1:0] sel,
   output logic            tick_out
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic [W-1:0] last;
   logic         at_last;

   // Terminal count for the selected ratio.
   assign last    = (sel == 2'h3) ? `SBGT_DIV256_LAST :
                    (sel == 2'h2) ? `SBGT_DIV64_LAST  :
                    (sel == 2'h1) ? `SBGT_DIV8_LAST   : `SBGT_DIV1_LAST;
   assign at_last  = (cnt_q >= last);
   assign tick_out = tick_in && at_last;
   assign cnt_d    = clr ? '0 : (tick_in ? (at_last ? '0 : cnt_q + 1'b1) : cnt_q);

   // The divide count clears when the timer stops so each start is clean.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule

`default_nettype wire

// >>> hdl/sbgt_edge_sync.sv
`include "sbgt_cfg.svh"
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage synchroniser with rising edge detect on the second stage.
// ----------------------------------------------------------------------------
module sbgt_edge_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      level,
   output logic      rise
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Only the second stage reads the first; the edge uses stages two and three.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign level = s2_q;
   assign rise  = s2_q && !s3_q;

endmodule

`default_nettype wire

// >>> verif/sbgt_asserts.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Port checks for the timer.
// ----------------------------------------------------------------------------
module sbgt_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        period_match_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic        acc;
   logic        ok;
   logic        clr;
   logic [15:0] ctrl_q;

   // Access decode; only the four word offsets are mapped.
   assign acc = psel && penable;
   assign ok  = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};
   assign clr = acc && pwrite && paddr == 12'h00c && pwdata[0] && pstrb[0];

   // Shadow of the control word, so read-back is judged bit for bit.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctrl_q <= 16'h0000;
      else if (acc && pwrite && paddr == 12'h000 && pstrb[1:0] == 2'b11)
         ctrl_q <= pwdata[15:0] & 16'ha076;

   sequence s_bad;
      acc && !ok;
   endsequence

   sequence s_drop;
      period_match_flag ##1 !period_match_flag;
   endsequence

   pready_high_a: assert property (pready) else $error("pready low");
   err_in_access_a: assert property (pslverr |-> acc) else $error("stray pslverr");
   bad_addr_err_a: assert property (s_bad |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   good_addr_ok_a: assert property (acc && ok |-> !pslverr) else $error("mapped refused");
   upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   ctrl_rdback_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == {16'h0, ctrl_q})
      else $error("control read-back wrong");
   flag_sticky_a: assert property (s_drop |-> $past(clr))
      else $error("flag dropped without clear");
   // Every tick is gated by the enable, so the flag rises one cycle after a match while running.
   flag_cause_a: assert property ($rose(period_match_flag) |-> ctrl_q[15] ||
      $past(ctrl_q[15]) || $past(ctrl_q[15], 2) || $past(ctrl_q[15], 4))
      else $error("flag rose while stopped");
endmodule

bind sbgt_timer sbgt_asserts sbgt_asserts_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .period_match_flag(period_match_flag)
);

`default_nettype wire

// >>> verif/sbgt_timer_bench.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Self-checking bench for the timer.
// ----------------------------------------------------------------------------
module sbgt_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        icc;
   logic        pin;
   logic        gate;
   logic        idle;
   logic        flag;
   logic [31:0] rd_q;
   logic        er_q;
   logic [31:0] seed;
   logic [15:0] s;
   int          err_total;
   int          comparisons;
   int          cyc = 0;
   int          n;

   sbgt_timer sbgt_timer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instruction_cycle_clock(icc), .ext_count_clock_pin(pin),
      .gate_in(gate), .idle_mode(idle), .period_match_flag(flag)
   );

   // Free-running bus clock.
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Prescale ratios 1, 8, 64 and 256 as right shifts.
   function automatic int shf(input logic [1:0] p);
      return (p == 2'h3) ? 8 : 3 * p;
   endfunction

   task automatic finish_test();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask

   // Read data and error are taken at the edge that samples pready high, before
   // that edge's register updates land; the request is released only afterwards.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd_q = prdata;
      er_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pulses one source, then lets the synchroniser pipeline drain.
   task automatic tick(input int k, input logic e);
      repeat (k)
      begin
         @(posedge pclk);
         if (e)
            pin <= 1'b1;
         else
            icc <= 1'b1;
         @(posedge pclk);
         if (e)
            pin <= 1'b0;
         else
            icc <= 1'b0;
      end
      repeat (6) @(posedge pclk);
   endtask

   task automatic run(input logic [15:0] c, input int k, input logic e, input int a);
      s = 16'(xs() & 32'hfff);
      apb(1'b1, 12'h004, {16'h0, s});
      apb(1'b1, 12'h000, {16'h0, c});
      tick(k, e);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("count", rd_q, {16'h0, s + 16'(a)});
   endtask

   // Watchdog against a hung handshake.
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         finish_test();
      end
   end

   // Main sequence.
   initial
   begin
      {presetn, psel, penable, pwrite, icc, pin, gate, idle} = '0;
      {paddr, pwdata, err_total, comparisons} = '0;
      seed = 32'h17;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", rd_q, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("period", rd_q, 32'hffff);
      apb(1'b1, 12'h000, 32'hffff);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", rd_q, 32'ha076);
      // The all-ones write left a running synchronous counter, which locks count writes.
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", {er_q, rd_q[30:0]}, 32'h80000000);
      for (int p = 0; p < 4; p++)
      begin
         n = int'(xs() % 8) + ((p == 3) ? 260 : 20 + p * 60);
         run(16'h8000 | 16'(p << 4) | 16'(xs() & 4), n, 1'b0, n >> shf(2'(p)));
      end
      run(16'h8006, 7, 1'b1, 7);
      run(16'h8042, 5, 1'b1, 5);
      run(16'h8006, 4, 1'b0, 0);
      run(16'h8000, 4, 1'b1, 0);
      run(16'h0000, 5, 1'b0, 0);
      gate <= 1'b1;
      run(16'h8040, 6, 1'b0, 6);
      gate <= 1'b0;
      run(16'h8040, 6, 1'b0, 0);
      idle <= 1'b1;
      run(16'ha000, 5, 1'b0, 0);
      run(16'h8000, 5, 1'b0, 5);
      idle <= 1'b0;
      apb(1'b1, 12'h004, 32'h55);
      apb(1'b1, 12'h000, 32'h8006);
      apb(1'b1, 12'h004, 32'h1234);
      apb(1'b0, 12'h004, 32'h0);
      chk("locked", rd_q, 32'h55);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h5);
      apb(1'b1, 12'h000, 32'h8000);
      tick(8, 1'b0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("wrap", rd_q, 32'h2);
      chk("flag", {31'h0, flag}, 32'h1);
      apb(1'b1, 12'h00c, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("status", rd_q & 32'h1, 32'h0);
      finish_test();
   end
endmodule

`default_nettype wire
